// *** ass_scan_sequencer.v ***
// acquisition scan sequencer with counters, digital ports, timers, dac pacing
//---------------------------------------------------------------------------
// What this block does
// - scan whose total sample time exceeds 200 kHz period is refused.
// - each list entry picks 5, 10 or 1000 us sampling interval.
// - scan period is the sum of every entry's sampling interval.
// - 16 single-ended or 8 differential inputs, chosen per entry.
// - per-entry unipolar/bipolar range and gain 1 to 64.
// - analog expansion enabled consumes one local analog channel.
// - four 16-bit counters, optionally cascaded into two 32-bit.
// - pulse mode counter clears when read into the scan.
// - totalize mode counter free-runs, never cleared in acquisition.
// - async read clears in clear-on-read mode, keeps in totalize.
// - async reads only for counters/digital not in the scan list.
// - input scan paced by internal pacer or external clock.
// - output pacing from input clock, own pacer or external clock.
// - every output tick updates all waveform channels together.
// - each dac is waveform or takes direct async updates.
// - waveform samples come from one shared buffer.
// - wide port drives on write, samples pins on read.
// - three 8-bit ports with config register setting direction.
// - digital expansion takes three-port writes and data reads; scan samples and config reads stay local.
// - timers accept new settings any time, undisturbed by others.
//---------------------------------------------------------------------------
`timescale 1ns/1ps
`include "ass_consts.vh"
module ass_scan_sequencer #(
	parameter LIST_DEPTH = 16,
	parameter WAVE_DEPTH = 64,
	parameter PACE_W = 24
) (
	input wire clk_sys,
	input wire reset_n,
	input wire clk_en,
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	input wire ext_in_clk,
	input wire ext_out_clk,
	input wire [3:0] count_in,
	output reg [3:0] ain_mux_sel,
	output reg ain_diff,
	output reg ain_bipolar,
	output reg [2:0] ain_gain,
	output reg ain_convert,
	input wire [15:0] ain_data,
	input wire [15:0] wide_dio_in,
	output reg [15:0] wide_dio_out,
	output reg wide_dio_oe,
	input wire [23:0] tp_in,
	output reg [23:0] tp_out,
	output reg [2:0] tp_oe,
	output reg [7:0] dexp_addr,
	output reg [7:0] dexp_wdata,
	output reg dexp_wr,
	input wire [7:0] dexp_rdata,
	output reg [15:0] analog_out_ch0,
	output reg [15:0] analog_out_ch1,
	output reg [15:0] analog_out_ch2,
	output reg [15:0] analog_out_ch3,
	output reg dac_update,
	output reg pulse_timer_a,
	output reg pulse_timer_b,
	output reg scan_refused
);
	localparam LW = $clog2(LIST_DEPTH);
	localparam WW = $clog2(WAVE_DEPTH);
	localparam [23:0] C5 = `ASS_T5_NS / `ASS_CLK_NS;
	localparam [23:0] C10 = `ASS_T10_NS / `ASS_CLK_NS;
	localparam [23:0] C1000 = `ASS_T1000_NS / `ASS_CLK_NS;
	localparam [23:0] CMIN = `ASS_MIN_SCAN_NS / `ASS_CLK_NS;
	localparam S_IDLE = 3'b001;
	localparam S_SAMP = 3'b010;
	localparam S_NEXT = 3'b100;

	function [23:0] si_cycles;
		input [1:0] code;
		begin
			case (code)
				`ASS_SI_5US: si_cycles = C5;
				`ASS_SI_10US: si_cycles = C10;
				default: si_cycles = C1000;
			endcase
		end
	endfunction

	// entry: [17:16] kind, [15:14] interval, [13] diff, [12] bipolar, [11:9] gain, [3:0] ch
	reg [17:0] list_reg [0:LIST_DEPTH-1];
	reg [15:0] wave_reg [0:WAVE_DEPTH-1];
	reg [31:0] ctrl_reg;
	reg [PACE_W-1:0] pace_in_reg, pace_out_reg, pin_cnt_reg, pout_cnt_reg;
	reg [LW:0] len_reg;
	reg [LW-1:0] sel_reg, idx_reg;
	reg [WW-1:0] wsel_reg, wptr_reg;
	reg [3:0] cmode_reg;
	reg [15:0] cnt_reg [0:3];
	reg [15:0] cnt_hi_reg;
	reg [3:0] cin_q_reg;
	reg [31:0] timer_a_reg, timer_b_reg;
	reg [31:0] ta_cnt_reg, tb_cnt_reg;
	reg [7:0] tp_cfg_reg;
	reg [2:0] state_reg;
	reg [23:0] samp_cnt_reg;
	reg [31:0] scan_data_reg;
	reg ein_q_reg, eout_q_reg, in_tick_q_reg;
	reg aw_hold_reg, w_hold_reg;
	reg [7:0] aw_addr_reg;
	reg [31:0] w_data_reg;
	reg [3:0] cnt_clr;
	reg [23:0] sum;
	reg [3:0] in_scan;
	reg dig_in_scan;
	integer i;
	integer j;

	wire run = ctrl_reg[`ASS_CTRL_RUN];
	wire casc = ctrl_reg[`ASS_CTRL_CASC];
	wire dexp = ctrl_reg[`ASS_CTRL_DEXP];
	wire [3:0] wave_en = ctrl_reg[`ASS_CTRL_WAVE+3:`ASS_CTRL_WAVE];
	wire [17:0] cur = list_reg[idx_reg];

	// scan length check and ownership of counters/digital by the scan
	always @* begin
		sum = 24'h0;
		in_scan = 4'h0;
		dig_in_scan = 1'b0;
		for (j = 0; j < LIST_DEPTH; j = j + 1) begin
			if (j < len_reg) begin
				sum = sum + si_cycles(list_reg[j][15:14]);
				if (list_reg[j][17:16] == `ASS_K_CNT)
					in_scan[list_reg[j][1:0]] = 1'b1;
				if (list_reg[j][17:16] == `ASS_K_DIG)
					dig_in_scan = 1'b1;
			end
		end
	end
	wire too_long = (sum > CMIN);

	//---------------------------------------------------------------------------
	// pacing
	//---------------------------------------------------------------------------
	wire pin_tick = ctrl_reg[`ASS_CTRL_INCLK] ? (ext_in_clk & ~ein_q_reg) :
		(pin_cnt_reg == pace_in_reg);
	reg out_tick;
	always @* begin
		case (ctrl_reg[`ASS_CTRL_OUTSEL+1:`ASS_CTRL_OUTSEL])
			2'h0: out_tick = in_tick_q_reg;
			2'h1: out_tick = (pout_cnt_reg == pace_out_reg);
			default: out_tick = ext_out_clk & ~eout_q_reg;
		endcase
	end

	//---------------------------------------------------------------------------
	// axi4-lite slave, one outstanding access each way
	//---------------------------------------------------------------------------
	assign s_axi_awready = ~aw_hold_reg & ~s_axi_bvalid;
	assign s_axi_wready = ~w_hold_reg & ~s_axi_bvalid;
	assign s_axi_arready = ~s_axi_rvalid;
	wire do_wr = aw_hold_reg & w_hold_reg;
	wire do_rd = s_axi_arvalid & ~s_axi_rvalid;
	wire [7:0] ra = s_axi_araddr;
	// local analog channel lost to expansion: top one is reserved
	wire [3:0] ain_max = ctrl_reg[`ASS_CTRL_AEXP] ? 4'hE : 4'hF;

	// counter clears: pulse-mode scan sample, clear-on-read async read
	always @* begin
		cnt_clr = 4'h0;
		if (state_reg == S_SAMP && samp_cnt_reg == 24'h0 && cur[17:16] != `ASS_K_AIN &&
			cur[17:16] != `ASS_K_DIG && !cmode_reg[cur[1:0]])
			cnt_clr[cur[1:0]] = 1'b1;
		if (do_rd && ra == `ASS_CNT_RD && !in_scan[sel_reg[1:0]] &&
			!cmode_reg[sel_reg[1:0]]) begin
			if (casc) begin
				cnt_clr[{sel_reg[1], 1'b0}] = 1'b1;
				cnt_clr[{sel_reg[1], 1'b1}] = 1'b1;
			end else
				cnt_clr[sel_reg[1:0]] = 1'b1;
		end
	end

	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			ctrl_reg <= 32'h0;
			pace_in_reg <= {PACE_W{1'b0}};
			pace_out_reg <= {PACE_W{1'b0}};
			pin_cnt_reg <= {PACE_W{1'b0}};
			pout_cnt_reg <= {PACE_W{1'b0}};
			len_reg <= {(LW+1){1'b0}};
			sel_reg <= {LW{1'b0}};
			wsel_reg <= {WW{1'b0}};
			wptr_reg <= {WW{1'b0}};
			idx_reg <= {LW{1'b0}};
			cmode_reg <= 4'h0;
			cnt_hi_reg <= 16'h0;
			cin_q_reg <= 4'h0;
			timer_a_reg <= 32'h0;
			timer_b_reg <= 32'h0;
			ta_cnt_reg <= 32'h0;
			tb_cnt_reg <= 32'h0;
			tp_cfg_reg <= 8'h00;
			state_reg <= S_IDLE;
			samp_cnt_reg <= 24'h0;
			scan_data_reg <= 32'h0;
			ein_q_reg <= 1'b0;
			eout_q_reg <= 1'b0;
			in_tick_q_reg <= 1'b0;
			aw_hold_reg <= 1'b0;
			w_hold_reg <= 1'b0;
			aw_addr_reg <= 8'h00;
			w_data_reg <= 32'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'h0;
			s_axi_rvalid <= 1'b0;
			s_axi_rresp <= 2'h0;
			s_axi_rdata <= 32'h0;
			ain_mux_sel <= 4'h0;
			ain_diff <= 1'b0;
			ain_bipolar <= 1'b0;
			ain_gain <= 3'h0;
			ain_convert <= 1'b0;
			wide_dio_out <= 16'h0;
			wide_dio_oe <= 1'b0;
			tp_out <= 24'h0;
			tp_oe <= 3'h0;
			dexp_addr <= 8'h00;
			dexp_wdata <= 8'h00;
			dexp_wr <= 1'b0;
			analog_out_ch0 <= 16'h0;
			analog_out_ch1 <= 16'h0;
			analog_out_ch2 <= 16'h0;
			analog_out_ch3 <= 16'h0;
			dac_update <= 1'b0;
			pulse_timer_a <= 1'b0;
			pulse_timer_b <= 1'b0;
			scan_refused <= 1'b0;
			for (i = 0; i < 4; i = i + 1)
				cnt_reg[i] <= 16'h0;
			for (i = 0; i < LIST_DEPTH; i = i + 1)
				list_reg[i] <= 18'h0;
			for (i = 0; i < WAVE_DEPTH; i = i + 1)
				wave_reg[i] <= 16'h0;
		end else if (clk_en) begin
			ein_q_reg <= ext_in_clk;
			eout_q_reg <= ext_out_clk;
			in_tick_q_reg <= pin_tick & run & (state_reg == S_IDLE);
			pin_cnt_reg <= (pin_cnt_reg == pace_in_reg) ? {PACE_W{1'b0}} : pin_cnt_reg + 1'b1;
			pout_cnt_reg <= (pout_cnt_reg == pace_out_reg) ? {PACE_W{1'b0}} :
				pout_cnt_reg + 1'b1;
			ain_convert <= 1'b0;
			dexp_wr <= 1'b0;
			dac_update <= 1'b0;
			scan_refused <= run & too_long;
			// sequencer: ticks arriving mid-scan are dropped
			case (state_reg)
				S_IDLE: begin
					idx_reg <= {LW{1'b0}};
					if (run && pin_tick && !too_long && len_reg != 0)
						state_reg <= S_NEXT;
				end
				S_NEXT: begin
					ain_mux_sel <= (cur[3:0] > ain_max) ? ain_max : cur[3:0];
					ain_diff <= cur[13];
					ain_bipolar <= cur[12];
					ain_gain <= cur[11:9];
					samp_cnt_reg <= si_cycles(cur[15:14]) - 24'h1;
					state_reg <= S_SAMP;
				end
				S_SAMP: begin
					if (samp_cnt_reg == 24'h0) begin
						case (cur[17:16])
							`ASS_K_AIN: begin
								ain_convert <= 1'b1;
								scan_data_reg <= {16'h0, ain_data};
							end
							`ASS_K_DIG: scan_data_reg <= {tp_in[7:0], wide_dio_in, 8'h00};
							default: begin
								scan_data_reg <= {cnt_reg[{cur[1], 1'b1}], cnt_reg[cur[1:0]]};
							end
						endcase
						if ({1'b0, idx_reg} + 1'b1 >= len_reg)
							state_reg <= S_IDLE;
						else begin
							idx_reg <= idx_reg + 1'b1;
							state_reg <= S_NEXT;
						end
					end else
						samp_cnt_reg <= samp_cnt_reg - 24'h1;
				end
				default: state_reg <= S_IDLE;
			endcase
			// waveform outputs all change on one tick
			if (out_tick && run && wave_en != 4'h0) begin
				dac_update <= 1'b1;
				if (wave_en[0]) analog_out_ch0 <= wave_reg[wptr_reg];
				if (wave_en[1]) analog_out_ch1 <= wave_reg[wptr_reg];
				if (wave_en[2]) analog_out_ch2 <= wave_reg[wptr_reg];
				if (wave_en[3]) analog_out_ch3 <= wave_reg[wptr_reg];
				wptr_reg <= wptr_reg + 1'b1;
			end
			// pulse timers run independently of the scan
			ta_cnt_reg <= (ta_cnt_reg >= timer_a_reg) ? 32'h0 : ta_cnt_reg + 32'h1;
			tb_cnt_reg <= (tb_cnt_reg >= timer_b_reg) ? 32'h0 : tb_cnt_reg + 32'h1;
			pulse_timer_a <= (timer_a_reg != 32'h0) && (ta_cnt_reg == 32'h0);
			pulse_timer_b <= (timer_b_reg != 32'h0) && (tb_cnt_reg == 32'h0);
			// write channel
			if (s_axi_awvalid && s_axi_awready) begin
				aw_hold_reg <= 1'b1;
				aw_addr_reg <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_hold_reg <= 1'b1;
				w_data_reg <= s_axi_wdata;
			end
			if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
			if (do_wr) begin
				aw_hold_reg <= 1'b0;
				w_hold_reg <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= 2'h0;
				case (aw_addr_reg)
					`ASS_CTRL: ctrl_reg <= w_data_reg;
					`ASS_PACE_IN: pace_in_reg <= w_data_reg[PACE_W-1:0];
					`ASS_PACE_OUT: pace_out_reg <= w_data_reg[PACE_W-1:0];
					`ASS_LEN: len_reg <= w_data_reg[LW:0];
					`ASS_CHSEL: begin
						sel_reg <= w_data_reg[LW-1:0];
						wsel_reg <= w_data_reg[16+WW-1:16];
					end
					`ASS_CHCFG: begin
						if (!run) list_reg[sel_reg] <= w_data_reg[17:0];
						if (w_data_reg[31]) wave_reg[wsel_reg] <= w_data_reg[31:16] & 16'h7FFF
							| {1'b0, 15'h0};
					end
					`ASS_CNT_MODE: cmode_reg <= w_data_reg[3:0];
					`ASS_WIDE_DIO: begin
						wide_dio_out <= w_data_reg[15:0];
						wide_dio_oe <= 1'b1;
					end
					`ASS_TP_CFG: begin
						if (dexp) begin
							dexp_addr <= 8'h03;
							dexp_wdata <= w_data_reg[7:0];
							dexp_wr <= 1'b1;
						end else begin
							tp_cfg_reg <= w_data_reg[7:0];
							tp_oe <= w_data_reg[2:0];
						end
					end
					`ASS_TP_DATA: begin
						if (dexp) begin
							dexp_addr <= {6'h0, w_data_reg[25:24]};
							dexp_wdata <= w_data_reg[7:0];
							dexp_wr <= 1'b1;
						end else
							tp_out <= w_data_reg[23:0];
					end
					`ASS_DAC_DIRECT: begin
						case (w_data_reg[17:16])
							2'h0: if (!wave_en[0]) analog_out_ch0 <= w_data_reg[15:0];
							2'h1: if (!wave_en[1]) analog_out_ch1 <= w_data_reg[15:0];
							2'h2: if (!wave_en[2]) analog_out_ch2 <= w_data_reg[15:0];
							default: if (!wave_en[3]) analog_out_ch3 <= w_data_reg[15:0];
						endcase
					end
					`ASS_TIMER_A: timer_a_reg <= w_data_reg;
					`ASS_TIMER_B: timer_b_reg <= w_data_reg;
					default: s_axi_bresp <= 2'h2;
				endcase
			end
			// read channel
			if (s_axi_rvalid && s_axi_rready)
				s_axi_rvalid <= 1'b0;
			if (do_rd) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= 2'h0;
				s_axi_rdata <= 32'h0;
				case (ra)
					`ASS_CTRL: s_axi_rdata <= ctrl_reg;
					`ASS_STAT: s_axi_rdata <= {16'h0, 8'h0,
						3'h0, too_long, in_scan};
					`ASS_PACE_IN: s_axi_rdata <= {{(32-PACE_W){1'b0}}, pace_in_reg};
					`ASS_PACE_OUT: s_axi_rdata <= {{(32-PACE_W){1'b0}}, pace_out_reg};
					`ASS_LEN: s_axi_rdata <= {{(31-LW){1'b0}}, len_reg};
					`ASS_CHCFG: s_axi_rdata <= {14'h0, list_reg[sel_reg]};
					`ASS_CNT_MODE: s_axi_rdata <= {28'h0, cmode_reg};
					`ASS_CNT_RD: begin
						// counter number is sel_reg[1:0], not read from a list entry
						if (in_scan[sel_reg[1:0]]) s_axi_rresp <= 2'h2;
						else begin
							s_axi_rdata <= casc ? {cnt_reg[{sel_reg[1], 1'b1}],
								cnt_reg[{sel_reg[1], 1'b0}]} : {16'h0, cnt_reg[sel_reg[1:0]]};
						end
					end
					`ASS_WIDE_DIO: begin
						if (dig_in_scan) s_axi_rresp <= 2'h2;
						else s_axi_rdata <= {16'h0, wide_dio_in};
					end
					`ASS_TP_DATA: begin
						if (dig_in_scan) s_axi_rresp <= 2'h2;
						else if (dexp) s_axi_rdata <= {24'h0, dexp_rdata};
						else s_axi_rdata <= {8'h0, tp_in};
					end
					`ASS_TP_CFG: s_axi_rdata <= {24'h0, tp_cfg_reg};
					`ASS_TIMER_A: s_axi_rdata <= timer_a_reg;
					`ASS_TIMER_B: s_axi_rdata <= timer_b_reg;
					`ASS_SCAN_DATA: s_axi_rdata <= scan_data_reg;
					default: s_axi_rresp <= 2'h2;
				endcase
			end
			// counters; carry from low into high half when cascaded
			cin_q_reg <= count_in;
			for (i = 0; i < 4; i = i + 1) begin
				if (cnt_clr[i])
					cnt_reg[i] <= 16'h0;
				else if ((i[0] && casc) ? (count_in[i-1] & ~cin_q_reg[i-1] &&
					cnt_reg[i-1] == 16'hFFFF) : (count_in[i] & ~cin_q_reg[i]))
					cnt_reg[i] <= cnt_reg[i] + 16'h1;
			end
		end
	end
endmodule

// *** ass_consts.vh ***
// constants for the acquisition scan sequencer
`ifndef ASS_CONSTS_VH
`define ASS_CONSTS_VH
// register byte offsets
`define ASS_CTRL 8'h00
`define ASS_STAT 8'h04
`define ASS_PACE_IN 8'h08
`define ASS_PACE_OUT 8'h0C
`define ASS_LEN 8'h10
`define ASS_CHCFG 8'h14
`define ASS_CHSEL 8'h18
`define ASS_CNT_MODE 8'h1C
`define ASS_CNT_RD 8'h20
`define ASS_WIDE_DIO 8'h24
`define ASS_TP_DATA 8'h28
`define ASS_TP_CFG 8'h2C
`define ASS_DAC_DIRECT 8'h30
`define ASS_TIMER_A 8'h34
`define ASS_TIMER_B 8'h38
`define ASS_SCAN_DATA 8'h3C
// ctrl fields
`define ASS_CTRL_RUN 0
`define ASS_CTRL_INCLK 1
`define ASS_CTRL_OUTSEL 2
`define ASS_CTRL_WAVE 4
`define ASS_CTRL_AEXP 8
`define ASS_CTRL_DEXP 9
`define ASS_CTRL_CASC 10
// sampling interval codes and times in ns
`define ASS_SI_5US 2'h0
`define ASS_SI_10US 2'h1
`define ASS_SI_1000US 2'h2
`define ASS_T5_NS 5000
`define ASS_T10_NS 10000
`define ASS_T1000_NS 1000000
`define ASS_CLK_NS 100
// minimum scan period: 1 / 200 kHz
`define ASS_MIN_SCAN_NS 5000
// channel kinds
`define ASS_K_AIN 2'h0
`define ASS_K_DIG 2'h1
`define ASS_K_CNT 2'h2
`endif

// *** ass_properties.sv ***
// port-level assertions for the scan sequencer
`timescale 1ns/1ps
module ass_props (
	input wire clk_sys,
	input wire reset_n,
	input wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire s_axi_rvalid,
	input wire [1:0] s_axi_rresp,
	input wire [31:0] s_axi_rdata,
	input wire ain_convert,
	input wire dac_update,
	input wire scan_refused,
	input wire [15:0] wide_dio_out,
	input wire [23:0] tp_out,
	input wire [2:0] tp_oe,
	input wire [15:0] analog_out_ch0,
	input wire dexp_wr
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	//--------------------------------
	// sequences
	//--------------------------------
	// 5 us at 100 ns is 50 cycles, so 8 quiet cycles is a safe floor
	sequence s_conv_gap; !ain_convert [*8]; endsequence
	sequence s_dac_gap; !dac_update [*8]; endsequence
	sequence s_wr_done; $rose(s_axi_bvalid); endsequence
	//--------------------------------
	// properties
	//--------------------------------
	property p_conv_gap; ain_convert |=> s_conv_gap; endproperty
	property p_dac_gap; dac_update |=> s_dac_gap; endproperty
	property p_refused_idle; scan_refused |-> !ain_convert; endproperty
	property p_err_zero; s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0; endproperty
	property p_wide_by_wr; $changed(wide_dio_out) |-> s_wr_done; endproperty
	property p_tp_by_wr; $changed(tp_out) || $changed(tp_oe) |-> s_wr_done; endproperty
	property p_dac_cause; $changed(analog_out_ch0) |-> dac_update || $rose(s_axi_bvalid); endproperty
	property p_dexp_pulse; dexp_wr |=> !dexp_wr; endproperty
	property p_rd_answer; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
	property p_b_stand; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
	a_conv_gap: assert property (p_conv_gap) else $error("conversions too close");
	a_dac_gap: assert property (p_dac_gap) else $error("output ticks too close");
	a_refused_idle: assert property (p_refused_idle) else $error("refused scan converts");
	a_err_zero: assert property (p_err_zero) else $error("error read data not zero");
	a_wide_by_wr: assert property (p_wide_by_wr) else $error("wide port moved alone");
	a_tp_by_wr: assert property (p_tp_by_wr) else $error("three-port moved alone");
	a_dac_cause: assert property (p_dac_cause) else $error("dac changed without cause");
	a_dexp_pulse: assert property (p_dexp_pulse) else $error("expansion strobe too long");
	a_rd_answer: assert property (p_rd_answer) else $error("read answer late");
	a_b_stand: assert property (p_b_stand) else $error("write response dropped");
endmodule

// *** ass_front_model.sv ***
// analog front end and digital expansion bus model
`timescale 1ns/1ps
module ass_front_model (
	input wire clk_sys,
	input wire reset_n,
	input wire [3:0] ain_mux_sel,
	input wire ain_diff,
	input wire ain_bipolar,
	input wire [2:0] ain_gain,
	input wire ain_convert,
	output logic [15:0] ain_data,
	input wire [7:0] dexp_addr,
	input wire [7:0] dexp_wdata,
	input wire dexp_wr,
	output wire [7:0] dexp_rdata
);
	logic [7:0] mem_reg [0:255];
	initial begin
		for (int i = 0; i < 256; i++) begin
			mem_reg[i] = i[7:0] ^ 8'hA5;
		end
	end
	// result encodes the front end setup so a wrong mux shows in the data
	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			ain_data <= 16'hFFFF;
		end else if (ain_convert) begin
			ain_data <= {7'h50, ain_gain, ain_bipolar, ain_diff, ain_mux_sel};
		end
	end
	always @(posedge clk_sys) begin
		if (dexp_wr) begin
			mem_reg[dexp_addr] <= dexp_wdata;
		end
	end
	assign dexp_rdata = mem_reg[dexp_addr];
endmodule

// *** tb_ass_scan_sequencer.sv ***
// self-checking testbench for the scan sequencer
`timescale 1ns/1ps
`include "ass_consts.vh"
module tb_ass_scan_sequencer;
	logic clk_sys = 1'b0, reset_n = 1'b0, clk_en = 1'b1, ext_in_clk = 1'b0, ext_out_clk = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic [31:0] s_axi_wdata = 32'h0, d;
	logic [3:0] s_axi_wstrb = 4'hF, count_in = 4'h0;
	logic [15:0] wide_dio_in = 16'h0;
	logic [23:0] tp_in = 24'h0;
	logic [7:0] dexp_last = 8'h00;
	logic [1:0] r;
	int n, err_total = 0, comparisons = 0, cyc_total = 0;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata;
	wire [3:0] ain_mux_sel;
	wire [2:0] ain_gain, tp_oe;
	wire ain_diff, ain_bipolar, ain_convert, wide_dio_oe, dexp_wr, dac_update;
	wire pulse_timer_a, pulse_timer_b, scan_refused;
	wire [15:0] ain_data, wide_dio_out, analog_out_ch0, analog_out_ch1, analog_out_ch2;
	wire [15:0] analog_out_ch3;
	wire [23:0] tp_out;
	wire [7:0] dexp_addr, dexp_wdata, dexp_rdata;
	ass_scan_sequencer ass_scan_sequencer_inst (.clk_sys, .reset_n, .clk_en, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ext_in_clk, .ext_out_clk,
		.count_in, .ain_mux_sel, .ain_diff, .ain_bipolar, .ain_gain, .ain_convert, .ain_data,
		.wide_dio_in, .wide_dio_out, .wide_dio_oe, .tp_in, .tp_out, .tp_oe, .dexp_addr,
		.dexp_wdata, .dexp_wr, .dexp_rdata, .analog_out_ch0, .analog_out_ch1, .analog_out_ch2,
		.analog_out_ch3, .dac_update, .pulse_timer_a, .pulse_timer_b, .scan_refused);
	ass_front_model ass_front_model_inst (.clk_sys, .reset_n, .ain_mux_sel, .ain_diff,
		.ain_bipolar, .ain_gain, .ain_convert, .ain_data, .dexp_addr, .dexp_wdata, .dexp_wr,
		.dexp_rdata);
	always #50 clk_sys = ~clk_sys;
	always @(posedge clk_sys) begin
		if (dexp_wr) begin
			dexp_last <= dexp_wdata;
		end
	end
	//--------------------------------
	// run limit and verdict
	//--------------------------------
	always @(posedge clk_sys) begin
		cyc_total++;
		if (cyc_total == 30000) begin
			err_total++;
			end_sim;
		end
	end
	task end_sim;
		$display("comparisons=%0d err_total=%0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	//--------------------------------
	// bus and helper tasks
	//--------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
		@(posedge clk_sys);
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= v;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge clk_sys);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
		chk({30'h0, s_axi_bresp}, {30'h0, er});
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge clk_sys);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge clk_sys);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
		d = s_axi_rdata;
		r = s_axi_rresp;
	endtask
	// 0 conversion, 1 output tick, 2 timer a; n counts edges up to the hit
	task automatic wait_on(input int sel, input int lim);
		logic s;
		s = 1'b0;
		n = 0;
		while (!s && n < lim) begin
			@(posedge clk_sys);
			n++;
			s = (sel == 0) ? ain_convert : (sel == 1) ? dac_update :
				(sel == 2) ? pulse_timer_a : pulse_timer_b;
		end
	endtask
	task automatic pulse(input int k);
		repeat (k) begin
			@(posedge clk_sys) count_in <= 4'h1;
			repeat (3) @(posedge clk_sys);
			count_in <= 4'h0;
			repeat (3) @(posedge clk_sys);
		end
		repeat (4) @(posedge clk_sys);
	endtask
	//--------------------------------
	// scenarios
	//--------------------------------
	task automatic t_ports;
		rd(`ASS_STAT);
		chk(d, 32'h0);
		wr(`ASS_WIDE_DIO, 32'h0000A5C3, 2'h0);
		chk({15'h0, wide_dio_oe, wide_dio_out}, 32'h0001A5C3);
		wide_dio_in <= 16'h3C5A;
		tp_in <= 24'hC3A55A;
		rd(`ASS_WIDE_DIO);
		chk(d & 32'hFFFF, 32'h3C5A);
		wr(8'h40, 32'h1, 2'h2);
		rd(8'h40);
		chk({30'h0, r}, 32'h2);
		wr(`ASS_TP_CFG, 32'h5, 2'h0);
		wr(`ASS_TP_DATA, 32'h123456, 2'h0);
		chk({5'h0, tp_oe, tp_out}, 32'h05123456);
		rd(`ASS_TP_DATA);
		chk(d, 32'h00C3A55A);
	endtask
	task automatic t_counters;
		wr(`ASS_CNT_MODE, 32'h0, 2'h0);
		wr(`ASS_CHSEL, 32'h0, 2'h0);
		pulse(5);
		rd(`ASS_CNT_RD);
		chk(d, 32'h5);
		rd(`ASS_CNT_RD);
		chk(d, 32'h0);
		wr(`ASS_CNT_MODE, 32'h1, 2'h0);
		pulse(3);
		rd(`ASS_CNT_RD);
		chk(d, 32'h3);
		rd(`ASS_CNT_RD);
		chk(d, 32'h3);
		wr(`ASS_CTRL, 32'h400, 2'h0);
		rd(`ASS_CNT_RD);
		chk(d, 32'h3);
	endtask
	task automatic t_scan;
		wr(`ASS_CHCFG, 32'h00003203, 2'h0);
		wr(`ASS_LEN, 32'h1, 2'h0);
		wr(`ASS_PACE_IN, 32'd99, 2'h0);
		wr(`ASS_CTRL, 32'h1, 2'h0);
		wait_on(0, 400);
		chk({23'h0, ain_mux_sel, ain_diff, ain_bipolar, ain_gain}, 32'h79);
		wait_on(0, 400);
		chk(n, 100);
		clk_en <= 1'b0;
		repeat (50) @(posedge clk_sys);
		clk_en <= 1'b1;
		wait_on(0, 400);
		chk(n, 100);
		chk({31'h0, scan_refused}, 32'h0);
		wr(`ASS_PACE_OUT, 32'd99, 2'h0);
		wr(`ASS_CHCFG, 32'h92340000, 2'h0);
		wr(`ASS_CTRL, 32'h15, 2'h0);
		wait_on(1, 400);
		chk({16'h0, analog_out_ch0}, 32'h1234);
		wait_on(1, 400);
		chk(n, 100);
		wr(`ASS_DAC_DIRECT, 32'h0000BEEF, 2'h0);
		wr(`ASS_DAC_DIRECT, 32'h0001BEEF, 2'h0);
		chk(32'(analog_out_ch0 == 16'hBEEF), 32'h0);
		chk({analog_out_ch2, analog_out_ch1}, 32'h0000BEEF);
		chk({16'h0, analog_out_ch3}, 32'h0);
		wr(`ASS_TIMER_A, 32'd49, 2'h0);
		wait_on(2, 400);
		chk(32'(n < 400), 32'h1);
		wr(`ASS_TIMER_B, 32'd49, 2'h0);
		wait_on(3, 400);
		chk(32'(n < 400), 32'h1);
		wait_on(0, 400);
		wait_on(0, 400);
		chk(n, 100);
	endtask
	task automatic t_ext;
		wr(`ASS_CTRL, 32'h0, 2'h0);
		wr(`ASS_CHCFG, 32'h0000000F, 2'h0);
		wr(`ASS_CTRL, 32'h103, 2'h0);
		repeat (3) @(posedge clk_sys);
		ext_in_clk <= 1'b1;
		wait_on(0, 60);
		chk(32'(n < 60), 32'h1);
		chk({28'h0, ain_mux_sel}, 32'hE);
		ext_in_clk <= 1'b0;
	endtask
	task automatic t_refuse;
		wr(`ASS_CTRL, 32'h0, 2'h0);
		wr(`ASS_CHCFG, 32'h00004003, 2'h0);
		wr(`ASS_CTRL, 32'h1, 2'h0);
		wait_on(0, 300);
		chk(n, 300);
		chk({31'h0, scan_refused}, 32'h1);
		rd(`ASS_STAT);
		chk(d & 32'h10, 32'h10);
	endtask
	task automatic t_cnt_scan;
		wr(`ASS_CTRL, 32'h0, 2'h0);
		wr(`ASS_CHCFG, 32'h00020000, 2'h0);
		wr(`ASS_CTRL, 32'h1, 2'h0);
		rd(`ASS_STAT);
		chk(d & 32'h1F, 32'h1);
		rd(`ASS_CNT_RD);
		chk({r, d[29:0]}, 32'h80000000);
		wr(`ASS_CHSEL, 32'h1, 2'h0);
		rd(`ASS_CNT_RD);
		chk({30'h0, r}, 32'h0);
		repeat (200) @(posedge clk_sys);
		rd(`ASS_SCAN_DATA);
		chk(d, 32'h3);
		wr(`ASS_CNT_MODE, 32'h0, 2'h0);
		repeat (260) @(posedge clk_sys);
		rd(`ASS_SCAN_DATA);
		chk(d, 32'h0);
	endtask
	task automatic t_dexp;
		wr(`ASS_CTRL, 32'h200, 2'h0);
		wr(`ASS_TP_DATA, 32'h5A, 2'h0);
		@(posedge clk_sys);
		chk({24'h0, dexp_last}, 32'h5A);
		chk({8'h0, tp_out}, 32'h00123456);
		rd(`ASS_TP_DATA);
		chk(d & 32'hFF, 32'h5A);
	endtask
	initial begin
		repeat (10) @(posedge clk_sys);
		reset_n <= 1'b1;
		@(posedge clk_sys);
		t_ports();
		t_counters();
		t_scan();
		t_ext();
		t_refuse();
		t_cnt_scan();
		t_dexp();
		end_sim;
	end
endmodule
bind ass_scan_sequencer ass_props ass_props_inst (.clk_sys, .reset_n, .s_axi_bvalid,
	.s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rresp, .s_axi_rdata,
	.ain_convert, .dac_update, .scan_refused, .wide_dio_out, .tp_out, .tp_oe, .analog_out_ch0,
	.dexp_wr);
